/* File: usf_status_flags.sv */
// Status flag logic of the serial port: status register, receive buffer,
// transmit holding register and the read-then-access clear sequences.
// Assumes the receive shifter reports events as one-cycle pulses and the transmit shifter reports ready and busy as levels.
//
// Overview of operation
// - Eight read-only status bits: parity, noise, framing, overrun, rx idle, rx avail, tx idle, tx empty.
// - Parity error set on received parity mismatch, only while parity checking enabled.
// - Status read then data access clears parity, noise, framing and overrun flags.
// - Noise flag set with receive available flag, never for an overrun word.
// - Framing error flag set when the received character has a bad frame.
// - Overrun set on buffer overflow; blocks further words into the data register.
// - Receiver idle low from start bit detection until stop bit completes.
// - Receive available set when word enters data register; interrupt if enabled.
// - Noise, framing, parity flags set in the same cycle the word becomes available.
// - Receive available clears after status read then data read, if buffer empty.
// - Transmitter idle set when tx empty and nothing sending; line held high.
// - Status read with tx idle set then data write clears tx idle.
// - Tx empty set on shifter load and transmitter enable; cleared by read-write sequence.
// - Disabling clears receive and error flags, sets idle and empty flags, empties buffer.
// - Two-entry receive buffer feeds the shared data register.
`timescale 1ns/1ns
module usf_status_flags
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  // Configuration
  input  wire logic                  serial_function_enable_i,
  input  wire logic                  transmitter_enable_i,
  input  wire logic                  receive_interrupt_enable_i,
  input  wire logic                  parity_enable_i,
  input  wire logic                  parity_odd_i,
  // CPU register access
  input  wire logic                  status_rd_i,
  input  wire logic                  data_rd_i,
  input  wire logic                  data_wr_i,
  input  wire logic [USF_DATA_W-1:0] data_wdata_i,
  output logic      [7:0]            serial_status_o,
  output logic      [USF_DATA_W-1:0] data_rdata_o,
  output logic                       rx_irq_o,
  // Receive shifter
  input  wire logic                  rx_start_i,
  input  wire logic                  rx_stop_done_i,
  input  wire logic                  rx_word_done_i,
  input  wire logic [USF_DATA_W-1:0] rx_word_i,
  input  wire logic                  rx_parity_bit_i,
  input  wire logic                  rx_noise_i,
  input  wire logic                  rx_frame_bad_i,
  // Transmit shifter
  input  wire logic                  tx_shift_ready_i,
  input  wire logic                  tx_busy_i,
  input  wire logic                  tx_break_i,
  output logic                       tx_load_o,
  output logic      [USF_DATA_W-1:0] tx_data_o,
  output logic                       tx_line_idle_o
);
  usf_state_s q, d;
  logic [USF_ENTRY_W-1:0] head, nxt, push_entry;
  logic [USF_CNT_W-1:0]   cnt;
  logic push_ok, pop, ovf, avail, par_bad, seq_data, flush;
  logic [USF_ERR_W-1:0]   new_err;

  assign flush    = !serial_function_enable_i;
  assign par_bad  = parity_enable_i && ((^{rx_word_i, rx_parity_bit_i}) ^ parity_odd_i);
  assign push_entry = {rx_noise_i, rx_frame_bad_i, par_bad, rx_word_i};
  // Overrun blocks transfers; a word arriving into a full buffer is lost
  assign ovf      = rx_word_done_i && cnt == USF_CNT_2 && !q.flags[USF_B_OVERRUN_ERROR_FLAG];
  assign push_ok  = rx_word_done_i && cnt != USF_CNT_2 && !q.flags[USF_B_OVERRUN_ERROR_FLAG];
  assign seq_data = q.arm && (data_rd_i || data_wr_i);
  assign pop      = q.arm && q.seen_receive_data_available_flag && data_rd_i && cnt != USF_CNT_0;
  // A word reaches the data register position of the buffer
  assign avail = (push_ok && (cnt == USF_CNT_0 || (pop && cnt == USF_CNT_1)))
               || (pop && cnt == USF_CNT_2);
  assign new_err = (pop && cnt == USF_CNT_2) ? nxt[USF_E_NF:USF_E_PARITY_ERROR_FLAG]
                                             : push_entry[USF_E_NF:USF_E_PARITY_ERROR_FLAG];

  usf_rx_fifo u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (flush),
    .push_i      (push_ok && serial_function_enable_i),
    .push_data_i (push_entry),
    .pop_i       (pop),
    .head_o      (head),
    .next_o      (nxt),
    .count_o     (cnt)
  );

  always_comb begin
    d      = q;
    d.txld = 1'b0;
    d.irq  = 1'b0;
    d.transmitter_enable_prev = transmitter_enable_i;
    // Data access consumes the armed sequence; a status read re-arms it
    if (seq_data) begin
      d.flags[USF_B_PARITY_ERROR_FLAG] = 1'b0;
      d.flags[USF_B_NF]   = 1'b0;
      d.flags[USF_B_FRAMING_ERROR_FLAG] = 1'b0;
      d.flags[USF_B_OVERRUN_ERROR_FLAG] = 1'b0;
      d.arm = 1'b0;
      if (pop && cnt == USF_CNT_1) d.flags[USF_B_RECEIVE_DATA_AVAILABLE_FLAG] = 1'b0;
      if (data_wr_i) begin
        d.txbuf = data_wdata_i;
        if (q.seen_transmitter_idle_flag) d.flags[USF_B_TRANSMITTER_IDLE_FLAG] = 1'b0;
        if (q.seen_transmit_buffer_empty_flag) d.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] = 1'b0;
      end
    end
    if (status_rd_i) begin
      d.arm        = 1'b1;
      d.seen_receive_data_available_flag  = q.flags[USF_B_RECEIVE_DATA_AVAILABLE_FLAG];
      d.seen_transmitter_idle_flag = q.flags[USF_B_TRANSMITTER_IDLE_FLAG];
      d.seen_transmit_buffer_empty_flag  = q.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG];
    end
    // Hardware events win over the clears above
    if (avail) begin
      d.flags[USF_B_RECEIVE_DATA_AVAILABLE_FLAG] = 1'b1;
      d.irq = receive_interrupt_enable_i;
      if (new_err[2]) d.flags[USF_B_NF]   = 1'b1;
      if (new_err[1]) d.flags[USF_B_FRAMING_ERROR_FLAG] = 1'b1;
      if (new_err[0]) d.flags[USF_B_PARITY_ERROR_FLAG] = 1'b1;
    end
    if (ovf) d.flags[USF_B_OVERRUN_ERROR_FLAG] = 1'b1;
    if (rx_stop_done_i) d.flags[USF_B_RECEIVER_IDLE_FLAG] = 1'b1;
    if (rx_start_i) d.flags[USF_B_RECEIVER_IDLE_FLAG] = 1'b0;
    // Transmit holding register moves into the shifter
    if (!q.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] && !q.txld && tx_shift_ready_i) begin
      d.txld = 1'b1;
      d.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] = 1'b1;
    end
    if (transmitter_enable_i && !q.transmitter_enable_prev) d.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] = 1'b1;
    // The shifter reports busy only after it has taken the load pulse
    if (d.flags[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] && !tx_busy_i && !tx_break_i && !d.txld && !q.txld) begin
      d.flags[USF_B_TRANSMITTER_IDLE_FLAG] = 1'b1;
    end
    if (flush) begin
      d.flags = USF_STATUS_RST;
      d.arm   = 1'b0;
      d.txld  = 1'b0;
      d.irq   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q       <= '0;
      q.flags <= USF_STATUS_RST;
    end else begin
      q <= d;
    end
  end

  assign serial_status_o = q.flags;
  assign data_rdata_o    = head[USF_DATA_W-1:0];
  assign rx_irq_o        = q.irq;
  assign tx_load_o       = q.txld;
  assign tx_data_o       = q.txbuf;
  assign tx_line_idle_o  = q.flags[USF_B_TRANSMITTER_IDLE_FLAG];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_par;
    rx_word_done_i && cnt == USF_CNT_0 && par_bad && !q.flags[USF_B_OVERRUN_ERROR_FLAG]
      && serial_function_enable_i |=> serial_status_o[USF_B_PARITY_ERROR_FLAG];
  endproperty
  a_par: assert property (p_par) else $error("parity flag not set");

  property p_clr;
    seq_data && !avail && !ovf && serial_function_enable_i
      |=> serial_status_o[7:4] == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("error flags not cleared");

  property p_nf;
    $rose(serial_status_o[USF_B_NF]) |-> serial_status_o[USF_B_RECEIVE_DATA_AVAILABLE_FLAG];
  endproperty
  a_nf: assert property (p_nf) else $error("noise set without rx avail");

  property p_ovr_hold;
    serial_status_o[USF_B_OVERRUN_ERROR_FLAG] && !pop && serial_function_enable_i |=> $stable(cnt);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("buffer moved in overrun");

  property p_receiver_idle_flag;
    rx_start_i && serial_function_enable_i |=> !serial_status_o[USF_B_RECEIVER_IDLE_FLAG];
  endproperty
  a_receiver_idle_flag: assert property (p_receiver_idle_flag) else $error("rx idle not low");

  property p_irq;
    avail && receive_interrupt_enable_i && serial_function_enable_i
      |=> rx_irq_o && serial_status_o[USF_B_RECEIVE_DATA_AVAILABLE_FLAG] ##1 (!rx_irq_o || $past(avail));
  endproperty
  a_irq: assert property (p_irq) else $error("rx interrupt wrong");

  property p_receive_data_available_flag_hold;
    serial_status_o[USF_B_RECEIVE_DATA_AVAILABLE_FLAG] && !pop && serial_function_enable_i
      |=> serial_status_o[USF_B_RECEIVE_DATA_AVAILABLE_FLAG];
  endproperty
  a_receive_data_available_flag_hold: assert property (p_receive_data_available_flag_hold) else $error("rx avail lost");

  property p_txld;
    tx_load_o |-> serial_status_o[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG] && !$past(serial_status_o[USF_B_TRANSMIT_BUFFER_EMPTY_FLAG]);
  endproperty
  a_txld: assert property (p_txld) else $error("tx load without empty");

  property p_dis;
    !serial_function_enable_i |=> serial_status_o == USF_STATUS_RST && cnt == USF_CNT_0;
  endproperty
  a_dis: assert property (p_dis) else $error("disable state wrong");

  property p_ovf;
    ovf && serial_function_enable_i |=> serial_status_o[USF_B_OVERRUN_ERROR_FLAG] && cnt == USF_CNT_2;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not flagged");

  c_avail: cover property (avail ##1 rx_irq_o);
  c_ovf:   cover property (ovf);
  c_seq:   cover property (status_rd_i ##[1:4] pop);
  c_tx:    cover property (tx_load_o ##[1:20] serial_status_o[USF_B_TRANSMITTER_IDLE_FLAG]);
endmodule : usf_status_flags

/* File: usf_pkg.sv */
// Constants and state types shared by the serial status flag logic.
// Assumes a single system clock and an active-low asynchronous reset.
package usf_pkg;
  localparam int          USF_DATA_W  = 8;
  localparam int          USF_ERR_W   = 3;
  localparam int          USF_ENTRY_W = USF_DATA_W + USF_ERR_W;
  localparam int          USF_DEPTH   = 2;
  localparam int          USF_CNT_W   = 2;
  localparam logic [1:0]  USF_CNT_0   = 2'h0;
  localparam logic [1:0]  USF_CNT_1   = 2'h1;
  localparam logic [1:0]  USF_CNT_2   = 2'h2;
  // Status register bit positions
  localparam int          USF_B_PARITY_ERROR_FLAG  = 7;
  localparam int          USF_B_NF    = 6;
  localparam int          USF_B_FRAMING_ERROR_FLAG  = 5;
  localparam int          USF_B_OVERRUN_ERROR_FLAG  = 4;
  localparam int          USF_B_RECEIVER_IDLE_FLAG = 3;
  localparam int          USF_B_RECEIVE_DATA_AVAILABLE_FLAG  = 2;
  localparam int          USF_B_TRANSMITTER_IDLE_FLAG = 1;
  localparam int          USF_B_TRANSMIT_BUFFER_EMPTY_FLAG  = 0;
  localparam logic [7:0]  USF_STATUS_RST = 8'h0b;
  // Error field positions inside a buffered entry
  localparam int          USF_E_NF    = 10;
  localparam int          USF_E_FRAMING_ERROR_FLAG  = 9;
  localparam int          USF_E_PARITY_ERROR_FLAG  = 8;

  typedef struct packed {
    logic [7:0]            flags;
    logic                  arm;
    logic                  seen_receive_data_available_flag;
    logic                  seen_transmitter_idle_flag;
    logic                  seen_transmit_buffer_empty_flag;
    logic                  transmitter_enable_prev;
    logic [USF_DATA_W-1:0] txbuf;
    logic                  txld;
    logic                  irq;
  } usf_state_s;

  typedef struct packed {
    logic [USF_ENTRY_W-1:0] e0;
    logic [USF_ENTRY_W-1:0] e1;
    logic [USF_CNT_W-1:0]   cnt;
  } usf_fifo_s;
endpackage : usf_pkg

/* File: usf_rx_fifo.sv */
// Two-entry receive buffer; entry 0 is the word the CPU sees.
// Assumes the caller never pushes while full.
`timescale 1ns/1ns
module usf_rx_fifo
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_b_i,
  // Control
  input  wire logic                   flush_i,
  input  wire logic                   push_i,
  input  wire logic [USF_ENTRY_W-1:0] push_data_i,
  input  wire logic                   pop_i,
  // State
  output logic      [USF_ENTRY_W-1:0] head_o,
  output logic      [USF_ENTRY_W-1:0] next_o,
  output logic      [USF_CNT_W-1:0]   count_o
);
  usf_fifo_s q, d;

  always_comb begin
    d = q;
    if (flush_i) begin
      d.cnt = USF_CNT_0;
    end else if (pop_i && q.cnt != USF_CNT_0) begin
      d.e0 = q.e1;
      if (push_i) begin
        if (q.cnt == USF_CNT_1) d.e0 = push_data_i;
        else d.e1 = push_data_i;
      end else begin
        d.cnt = q.cnt - USF_CNT_1;
      end
    end else if (push_i && q.cnt != USF_CNT_2) begin
      if (q.cnt == USF_CNT_0) d.e0 = push_data_i;
      else d.e1 = push_data_i;
      d.cnt = q.cnt + USF_CNT_1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) q <= '0;
    else q <= d;
  end

  assign head_o  = q.e0;
  assign next_o  = q.e1;
  assign count_o = q.cnt;
endmodule : usf_rx_fifo

/* File: usf_link_model.sv */
// Behavioural receive and transmit shifters facing the status flag block.
// Assumes bench commands change at the falling clock edge.
`timescale 1ns/1ns
module usf_link_model
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  // Bench commands
  input  wire logic                  send_i,
  input  wire logic [USF_DATA_W-1:0] word_i,
  input  wire logic                  par_i,
  input  wire logic                  noise_i,
  input  wire logic                  bad_i,
  input  wire logic                  slow_i,
  // Block side
  input  wire logic                  tx_load_i,
  output logic                       rx_start_o,
  output logic                       rx_stop_done_o,
  output logic                       rx_word_done_o,
  output logic      [USF_DATA_W-1:0] rx_word_o,
  output logic                       rx_parity_bit_o,
  output logic                       rx_noise_o,
  output logic                       rx_frame_bad_o,
  output logic                       tx_shift_ready_o,
  output logic                       tx_busy_o
);
  logic [2:0] rc_q;
  logic [3:0] tc_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_q <= 3'h0;
      tc_q <= 4'h0;
    end else begin
      rc_q <= send_i ? 3'h4 : (rc_q != 3'h0 ? rc_q - 3'h1 : 3'h0);
      tc_q <= tx_load_i ? (slow_i ? 4'hc : 4'h3) : (tc_q != 4'h0 ? tc_q - 4'h1 : 4'h0);
    end
  end
  assign rx_start_o       = send_i;
  assign rx_word_done_o   = rc_q == 3'h2;
  assign rx_stop_done_o   = rc_q == 3'h1;
  // Qualifiers show the inverse outside the word strobe
  assign rx_word_o        = rx_word_done_o ? word_i : ~word_i;
  assign rx_parity_bit_o  = rx_word_done_o ? par_i : ~par_i;
  assign rx_noise_o       = rx_word_done_o ? noise_i : ~noise_i;
  assign rx_frame_bad_o   = rx_word_done_o ? bad_i : ~bad_i;
  assign tx_busy_o        = tc_q != 4'h0;
  assign tx_shift_ready_o = tc_q == 4'h0;
endmodule : usf_link_model

/* File: uart_status_flags_bench.sv */
// Self-checking bench for the serial status flag block.
// Assumes the link model stands in for both shifters.
`timescale 1ns/1ns
module uart_status_flags_bench
  import usf_pkg::*;
();
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, serial_function_enable_i = 1'b1;
  logic transmitter_enable_i = 1'b1, receive_interrupt_enable_i = 1'b1;
  logic parity_enable_i = 1'b1, parity_odd_i = 1'b0, tx_break_i = 1'b0;
  logic status_rd_i = 1'b0, data_rd_i = 1'b0, data_wr_i = 1'b0;
  logic send = 1'b0, par = 1'b0, noise = 1'b0, bad = 1'b0, slow = 1'b0;
  logic [7:0] data_wdata_i = 8'h00, word = 8'h00;
  logic [7:0] serial_status_o, data_rdata_o, rx_word_i, tx_data_o;
  logic rx_irq_o, rx_start_i, rx_stop_done_i, rx_word_done_i, rx_parity_bit_i;
  logic rx_noise_i, rx_frame_bad_i, tx_shift_ready_i, tx_busy_i, tx_load_o, tx_line_idle_o;
  int n_fail = 0, n_tests = 0, n_irq = 0, n_load = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (rx_irq_o === 1'b1) n_irq++;
    if (tx_load_o === 1'b1) n_load++;
  end
  usf_status_flags uut (
    .ref_clk_i, .rst_b_i, .serial_function_enable_i, .transmitter_enable_i,
    .receive_interrupt_enable_i, .parity_enable_i, .parity_odd_i, .status_rd_i, .data_rd_i,
    .data_wr_i, .data_wdata_i, .serial_status_o, .data_rdata_o, .rx_irq_o, .rx_start_i,
    .rx_stop_done_i, .rx_word_done_i, .rx_word_i, .rx_parity_bit_i, .rx_noise_i,
    .rx_frame_bad_i, .tx_shift_ready_i, .tx_busy_i, .tx_break_i, .tx_load_o, .tx_data_o,
    .tx_line_idle_o
  );
  usf_link_model link (
    .ref_clk_i, .rst_b_i, .send_i(send), .word_i(word), .par_i(par), .noise_i(noise),
    .bad_i(bad), .slow_i(slow), .tx_load_i(tx_load_o), .rx_start_o(rx_start_i),
    .rx_stop_done_o(rx_stop_done_i), .rx_word_done_o(rx_word_done_i), .rx_word_o(rx_word_i),
    .rx_parity_bit_o(rx_parity_bit_i), .rx_noise_o(rx_noise_i),
    .rx_frame_bad_o(rx_frame_bad_i), .tx_shift_ready_o(tx_shift_ready_i), .tx_busy_o(tx_busy_i)
  );
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // One CPU access: k = {status read, data read, data write}
  task acc(input logic [2:0] k, input logic [7:0] d);
    @(negedge ref_clk_i);
    {status_rd_i, data_rd_i, data_wr_i} = k;
    data_wdata_i = d;
    @(negedge ref_clk_i);
    {status_rd_i, data_rd_i, data_wr_i} = 3'h0;
  endtask : acc
  task rx(input logic [7:0] w, input logic p, input logic n, input logic b);
    @(negedge ref_clk_i);
    {send, word, par, noise, bad} = {1'b1, w, p, n, b};
    @(negedge ref_clk_i);
    send = 1'b0;
    chk(serial_status_o & 8'h08, 8'h00);
    repeat (5) @(negedge ref_clk_i);
  endtask : rx
  task wait_st(input int b, input logic v);
    int i;
    n_tests++;
    for (i = 0; i < 60 && serial_status_o[b] !== v; i++) @(negedge ref_clk_i);
    if (i == 60) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, serial_status_o, v);
      stop_test();
    end
  endtask : wait_st
  initial begin
    int k;
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    chk(serial_status_o, 8'h0b);
    chk({7'h0, tx_line_idle_o}, 8'h01);
    k = n_irq;
    rx(8'h5a, 1'b0, 1'b1, 1'b0);
    chk(serial_status_o, 8'h4f);
    chk(data_rdata_o, 8'h5a);
    chk(8'(n_irq - k), 8'h01);
    acc(3'h2, 8'h00);
    chk(serial_status_o, 8'h4f);
    acc(3'h4, 8'h00);
    acc(3'h2, 8'h00);
    chk(serial_status_o, 8'h0b);
    $display("test rx_noise done");
    parity_odd_i = 1'b1;
    rx(8'ha5, 1'b0, 1'b0, 1'b1);
    chk(serial_status_o, 8'haf);
    rx(8'h11, 1'b1, 1'b0, 1'b0);
    rx(8'h22, 1'b0, 1'b1, 1'b0);
    chk(serial_status_o, 8'hbf);
    chk(data_rdata_o, 8'ha5);
    acc(3'h4, 8'h00);
    acc(3'h2, 8'h00);
    chk(serial_status_o, 8'h0f);
    chk(data_rdata_o, 8'h11);
    acc(3'h4, 8'h00);
    acc(3'h2, 8'h00);
    chk(serial_status_o, 8'h0b);
    $display("test rx_fifo done");
    {parity_enable_i, receive_interrupt_enable_i} = 2'b00;
    k = n_irq;
    rx(8'ha5, 1'b0, 1'b0, 1'b0);
    chk(serial_status_o, 8'h0f);
    chk(8'(n_irq - k), 8'h00);
    rx(8'h01, 1'b0, 1'b1, 1'b1);
    rx(8'h02, 1'b0, 1'b0, 1'b0);
    chk(serial_status_o, 8'h1f);
    serial_function_enable_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(serial_status_o, 8'h0b);
    serial_function_enable_i = 1'b1;
    acc(3'h4, 8'h00);
    acc(3'h2, 8'h00);
    chk(serial_status_o, 8'h0b);
    $display("test disable done");
    acc(3'h4, 8'h00);
    acc(3'h1, 8'h3c);
    chk(serial_status_o, 8'h08);
    chk({7'h0, tx_line_idle_o}, 8'h00);
    chk(tx_data_o, 8'h3c);
    wait_st(USF_B_TRANSMIT_BUFFER_EMPTY_FLAG, 1'b1);
    @(negedge ref_clk_i);
    chk(serial_status_o & 8'h02, 8'h00);
    wait_st(USF_B_TRANSMITTER_IDLE_FLAG, 1'b1);
    chk(8'(n_load), 8'h01);
    chk({7'h0, tx_line_idle_o}, 8'h01);
    tx_break_i = 1'b1;
    acc(3'h4, 8'h00);
    acc(3'h1, 8'hc3);
    wait_st(USF_B_TRANSMIT_BUFFER_EMPTY_FLAG, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    chk(serial_status_o, 8'h09);
    tx_break_i = 1'b0;
    wait_st(USF_B_TRANSMITTER_IDLE_FLAG, 1'b1);
    $display("test tx done");
    slow = 1'b1;
    acc(3'h4, 8'h00);
    acc(3'h1, 8'h81);
    wait_st(USF_B_TRANSMIT_BUFFER_EMPTY_FLAG, 1'b1);
    acc(3'h4, 8'h00);
    acc(3'h1, 8'h7e);
    chk(serial_status_o, 8'h08);
    transmitter_enable_i = 1'b0;
    @(negedge ref_clk_i);
    transmitter_enable_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(serial_status_o & 8'h01, 8'h01);
    $display("test tx_enable done");
    stop_test();
  end
endmodule : uart_status_flags_bench
